/* File: bench/usart_spi_master_tb.sv */
// self-checking bench for the usart spi master core
// assumes usm_core and usm_slave_model are compiled before it
`timescale 1ns/1ps
module usart_spi_master_tb;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [1:0]  mode_sel = 2'h3;
  logic        pol = 1'b0;
  logic        pha = 1'b0;
  logic        lsb = 1'b0;
  logic        tx_en = 1'b0;
  logic        rx_en = 1'b0;
  logic [11:0] baud = 12'h000;
  logic        clk_dir = 1'b0;
  logic        data_wr = 1'b0;
  logic [7:0]  data_wdata = 8'h00;
  logic        data_rd = 1'b0;
  logic        tc_clr = 1'b0;
  logic        tc_ack = 1'b0;
  logic        act = 1'b0;
  logic        load = 1'b0;
  logic [7:0]  base = 8'h00;
  logic        miso;
  logic [7:0]  rx_q;
  logic [7:0]  data_rdata;
  logic        tc;
  logic        rc;
  logic        be;
  logic        fe;
  logic        ov;
  logic        pe;
  logic        sclk;
  logic        sclk_oe;
  logic        mosi;
  logic        mosi_oe;
  logic        rx_own;
  int          err_count = 0;
  int          n_checks = 0;
  int          n_edges = 0;

  always #25 ref_clk = ~ref_clk;
  always @(sclk) n_edges++;

  usm_core dut (
    .ref_clk(ref_clk), .rst(rst), .mode_select_bits(mode_sel),
    .clock_polarity_bit(pol), .clock_phase_bit(pha), .bit_order_select(lsb),
    .transmitter_enable_bit(tx_en), .receiver_enable_bit(rx_en),
    .baud_divisor(baud), .clock_pin_direction(clk_dir), .data_wr(data_wr),
    .data_wdata(data_wdata), .data_rd(data_rd), .tx_complete_clear(tc_clr),
    .tx_complete_ack(tc_ack), .serial_input_pin(miso), .data_rdata(data_rdata),
    .transmit_complete_flag(tc), .receive_complete_flag(rc), .buffer_empty_flag(be),
    .framing_error_flag(fe), .overrun_flag(ov), .parity_error_flag(pe),
    .transfer_clock_pin(sclk), .transfer_clock_oe(sclk_oe), .serial_output_pin(mosi),
    .serial_output_oe(mosi_oe), .serial_input_owned(rx_own));

  usm_slave_model slave (
    .ref_clk(ref_clk), .sclk(sclk), .mosi(mosi), .cpol(pol), .cpha(pha),
    .lsb_first(lsb), .act(act), .load(load), .base(base), .miso(miso), .rx_q(rx_q));

  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic step(input int n = 1);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask

  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_hi(input bit use_tc);
    int k;
    k = 0;
    while ((use_tc ? tc : be) !== 1'b1) begin
      step();
      k++;
      if (k > 3000) begin
        err_count++;
        $display("CHECK FAILED wait expected 1 seen timeout");
        conclude();
      end
    end
  endtask

  // strobe drops for a full edge so back-to-back calls never collide
  task automatic wr(input logic [7:0] b);
    wait_hi(1'b0);
    data_wr = 1'b1;
    data_wdata = b;
    step();
    data_wr = 1'b0;
    chk("buffer empty after write", 12'h000, 12'(be));
    step();
  endtask

  // a refused write must leave the buffer free
  task automatic wr_refused(input logic [7:0] b);
    data_wr = 1'b1;
    data_wdata = b;
    step();
    data_wr = 1'b0;
    chk("buffer empty after refused write", 12'h001, 12'(be));
    step();
  endtask

  task automatic pop();
    data_rd = 1'b1;
    step();
    data_rd = 1'b0;
    step();
  endtask

  task automatic rd(input logic [7:0] exp);
    chk("receive complete", 12'h001, 12'(rc));
    chk("data_rdata", 12'(exp), 12'(data_rdata));
    pop();
  endtask

  task automatic clr_tc(input bit use_ack);
    tc_clr = !use_ack;
    tc_ack = use_ack;
    step();
    tc_clr = 1'b0;
    tc_ack = 1'b0;
    step();
  endtask

  task automatic sload(input logic [7:0] sb);
    base = sb;
    load = 1'b1;
    act = 1'b1;
    step();
    load = 1'b0;
  endtask

  task automatic xfer(input logic [7:0] b, input logic [7:0] sb);
    sload(sb);
    wr(b);
    wait_hi(1'b1);
    act = 1'b0;
  endtask

  task automatic t_init();
    chk("buffer empty at reset", 12'h001, 12'(be));
    chk("tx complete at reset", 12'h000, 12'(tc));
    chk("error flags", 12'h000, 12'({fe, ov, pe}));
    chk("clock idle at reset", 12'h000, 12'(sclk));
    chk("mosi idle at reset", 12'h001, 12'(mosi));
    clk_dir = 1'b1;
    step();
    tx_en = 1'b1;
    rx_en = 1'b1;
    step();
    baud = 12'h003;
    step();
    chk("clock pin driven", 12'h001, 12'(sclk_oe));
    chk("output pin owned", 12'h001, 12'(mosi_oe));
    chk("input pin owned", 12'h001, 12'(rx_own));
  endtask

  task automatic t_modes();
    logic [7:0] b;
    logic [7:0] sb;
    for (int m = 0; m < 8; m++) begin
      pha = m[0];
      pol = m[1];
      lsb = m[2];
      step(2);
      b = 8'hc5 ^ 8'(m);
      sb = 8'h3a + 8'(m);
      xfer(b, sb);
      chk("slave received", 12'(b), 12'(rx_q));
      chk("clock idle level", 12'(pol), 12'(sclk));
      // phase 1 frames release the line one cycle after the flag
      step();
      chk("mosi idle", 12'h001, 12'(mosi));
      chk("tx complete", 12'h001, 12'(tc));
      rd(sb);
      clr_tc(1'b0);
      chk("tx complete cleared", 12'h000, 12'(tc));
    end
  endtask

  task automatic t_rate();
    int k;
    logic [11:0] d [4] = '{12'h000, 12'h001, 12'h002, 12'h005};
    for (int i = 0; i < 4; i++) begin
      baud = d[i];
      step();
      n_edges = 0;
      wr(8'h81);
      k = 0;
      while (n_edges < 1 && k < 200) begin
        step();
        k++;
      end
      k = 0;
      while (n_edges < 2 && k < 200) begin
        step();
        k++;
      end
      chk("half bit cycles", d[i] + 12'h001, 12'(k));
      wait_hi(1'b1);
      pop();
      clr_tc(1'b0);
    end
    baud = 12'h003;
    step();
  endtask

  task automatic t_b2b();
    n_edges = 0;
    sload(8'h70);
    wr(8'ha1);
    wr(8'h5e);
    chk("second byte waits", 12'h000, 12'(be));
    wait_hi(1'b1);
    chk("edges before complete", 12'h020, 12'(n_edges));
    chk("second byte received", 12'h05e, 12'(rx_q));
    act = 1'b0;
    rd(8'h70);
    rd(8'h71);
    clr_tc(1'b0);
  endtask

  task automatic t_ovf();
    sload(8'h40);
    for (int i = 0; i < 4; i++) begin
      wr(8'h10 + 8'(i));
    end
    wait_hi(1'b1);
    act = 1'b0;
    rd(8'h40);
    rd(8'h41);
    rd(8'h43);
    chk("rx empty after reads", 12'h000, 12'(rc));
    clr_tc(1'b1);
    chk("tx complete acked", 12'h000, 12'(tc));
  endtask

  task automatic t_refuse();
    tx_en = 1'b0;
    step(2);
    chk("output pin released", 12'h000, 12'(mosi_oe));
    n_edges = 0;
    wr_refused(8'h5a);
    step(20);
    chk("no clock without tx", 12'h000, 12'(n_edges));
    chk("no complete without tx", 12'h000, 12'(tc));
    tx_en = 1'b1;
    mode_sel = 2'h1;
    step(2);
    n_edges = 0;
    wr_refused(8'h5a);
    step(20);
    chk("no clock outside spi mode", 12'h000, 12'(n_edges));
    mode_sel = 2'h3;
    rx_en = 1'b0;
    step(2);
    chk("input pin released", 12'h000, 12'(rx_own));
    xfer(8'h66, 8'h11);
    chk("no rx when disabled", 12'h000, 12'(rc));
    clr_tc(1'b0);
    rx_en = 1'b1;
  endtask

  initial begin
    step(5);
    rst = 1'b0;
    t_init();
    t_modes();
    t_rate();
    t_b2b();
    t_ovf();
    t_refuse();
    conclude();
  end
endmodule

/* File: bench/usm_slave_model.sv */
// behavioural spi slave facing the usart spi master core
// assumes it shifts only on the master's transfer clock, with loads taken on ref_clk; frames are eight bits
`timescale 1ns/1ps
module usm_slave_model (
  input  wire logic       ref_clk,
  input  wire logic       sclk,
  input  wire logic       mosi,
  input  wire logic       cpol,
  input  wire logic       cpha,
  input  wire logic       lsb_first,
  input  wire logic       act,
  input  wire logic       load,
  input  wire logic [7:0] base,
  output logic            miso,
  output logic [7:0]      rx_q
);
  logic [7:0] tx_q = 8'h00;
  logic       bit_q = 1'b1;
  int         idx = 0;

  initial rx_q = 8'h00;

  function automatic logic pick(input logic [7:0] b, input int i, input logic lsb);
    pick = lsb ? b[i] : b[7-i];
  endfunction

  // released line shows the inverse so a stale level never passes
  assign miso = act ? bit_q : ~bit_q;

  // each new frame answers with the next value, so lost bytes are visible
  task setup_edge();
    if (idx == 8) begin
      idx = 0;
      tx_q = tx_q + 8'h01;
    end
    bit_q = pick(tx_q, idx, lsb_first);
    idx++;
  endtask

  task sample_edge();
    rx_q = lsb_first ? {mosi, rx_q[7:1]} : {rx_q[6:0], mosi};
  endtask

  always @(posedge ref_clk) begin
    if (load) begin
      tx_q = base;
      idx = cpha ? 0 : 1;
      if (!cpha) begin
        bit_q = pick(base, 0, lsb_first);
      end
    end
  end

  // sample on rising when polarity equals phase, else on falling
  always @(posedge sclk) begin
    if (cpol == cpha) sample_edge();
    else setup_edge();
  end

  always @(negedge sclk) begin
    if (cpol == cpha) setup_edge();
    else sample_edge();
  end
endmodule

/* File: hdl/usm_baud_gen.sv */
// half-bit tick generator for the usart spi master
// assumes divisor comes from logic on ref_clk
`timescale 1ns/1ps
module usm_baud_gen #(
  parameter int DIV_W = usm_pkg::DIV_W
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             run,
  input  wire logic [DIV_W-1:0] divisor,
  output logic                  tick
);

  logic [DIV_W-1:0] cnt_r;
  logic [DIV_W-1:0] cnt_nxt;
  logic             tick_r;
  logic             tick_nxt;

  // restart from zero when idle so every frame opens with a full half-bit
  always_comb begin
    cnt_nxt  = '0;
    tick_nxt = 1'b0;
    if (run) begin
      if (cnt_r >= divisor) begin
        tick_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + {{(DIV_W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;

  property p_div_zero_every;
    @(posedge ref_clk) disable iff (rst)
      (run && $past(run) && $past(run, 2) && divisor == '0 && $stable(divisor)) |-> tick;
  endproperty
  a_div_zero_every: assert property (p_div_zero_every) else $error("tick missing at divisor 0");

  property p_div_one_gap;
    @(posedge ref_clk) disable iff (rst)
      (tick && run && divisor == {{(DIV_W-1){1'b0}}, 1'b1}) ##1 (run && $stable(divisor))
        |-> !tick ##1 (!run || tick);
  endproperty
  a_div_one_gap: assert property (p_div_one_gap) else $error("tick spacing wrong at divisor 1");

endmodule

/* File: hdl/usm_core.sv */
// usart transceiver in master spi mode: byte transfers, tx buffer, rx buffer
// assumes control bits and strobes come from logic on ref_clk; the serial
// input pin is asynchronous and is synchronised here
`timescale 1ns/1ps
module usm_core #(
  parameter int DIV_W = usm_pkg::DIV_W
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [1:0]       mode_select_bits,
  input  wire logic             clock_polarity_bit,
  input  wire logic             clock_phase_bit,
  input  wire logic             bit_order_select,
  input  wire logic             transmitter_enable_bit,
  input  wire logic             receiver_enable_bit,
  input  wire logic [DIV_W-1:0] baud_divisor,
  input  wire logic             clock_pin_direction,
  input  wire logic             data_wr,
  input  wire logic [7:0]       data_wdata,
  input  wire logic             data_rd,
  input  wire logic             tx_complete_clear,
  input  wire logic             tx_complete_ack,
  input  wire logic             serial_input_pin,
  output logic [7:0]            data_rdata,
  output logic                  transmit_complete_flag,
  output logic                  receive_complete_flag,
  output logic                  buffer_empty_flag,
  output logic                  framing_error_flag,
  output logic                  overrun_flag,
  output logic                  parity_error_flag,
  output logic                  transfer_clock_pin,
  output logic                  transfer_clock_oe,
  output logic                  serial_output_pin,
  output logic                  serial_output_oe,
  output logic                  serial_input_owned
);

  // bit_order_select high means lsb first
  function automatic logic out_bit(input logic [7:0] sh, input logic lsb);
    out_bit = lsb ? sh[0] : sh[7];
  endfunction

  function automatic logic [7:0] shift_out(input logic [7:0] sh, input logic lsb);
    shift_out = lsb ? {usm_pkg::LINE_IDLE, sh[7:1]} : {sh[6:0], usm_pkg::LINE_IDLE};
  endfunction

  function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic b,
                                          input logic lsb);
    shift_in = lsb ? {b, sh[7:1]} : {sh[6:0], b};
  endfunction

  usm_pkg::usm_state_e state_r;
  usm_pkg::usm_state_e state_nxt;
  logic       sin_s1_r;
  logic       sin_s2_r;
  logic       tick;
  logic       master_spi_mode;
  logic       lead;
  logic       sample;
  logic       frame_done;
  logic       tc_set;
  logic [7:0] rx_byte;
  logic [3:0] half_r;
  logic [3:0] half_nxt;
  logic [7:0] tx_sh_r;
  logic [7:0] tx_sh_nxt;
  logic [7:0] rx_sh_r;
  logic [7:0] rx_sh_nxt;
  logic [7:0] txbuf_r;
  logic [7:0] txbuf_nxt;
  logic       txbuf_v_r;
  logic       txbuf_v_nxt;
  logic       sck_r;
  logic       sck_nxt;
  logic       mosi_r;
  logic       mosi_nxt;
  logic       tc_r;
  logic       tc_nxt;
  logic       bempty_r;
  logic       bempty_nxt;
  logic       tx_oe_r;
  logic       tx_oe_nxt;
  logic       rx_own_r;
  logic       clk_oe_r;
  logic [7:0] mem_r [usm_pkg::RX_DEPTH];
  logic [7:0] mem_nxt [usm_pkg::RX_DEPTH];
  logic       rptr_r;
  logic       rptr_nxt;
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic [7:0] hold_r;
  logic [7:0] hold_nxt;
  logic       hold_v_r;
  logic       hold_v_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic       rxc_r;
  logic       rxc_nxt;

  assign master_spi_mode = (mode_select_bits == usm_pkg::MODE_MASTER_SPI_MODE);

  // only the transmitter paces the clock, so the receiver can never start one
  usm_baud_gen #(
    .DIV_W   (DIV_W)
  ) u_baud (
    .ref_clk (ref_clk),
    .rst     (rst),
    .run     (state_r == usm_pkg::USM_SHIFT),
    // divisor storage sits with the caller and resets to zero there
    .divisor (baud_divisor),
    .tick    (tick)
  );

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sin_s1_r <= 1'b0;
      sin_s2_r <= 1'b0;
    end else begin
      sin_s1_r <= serial_input_pin;
      sin_s2_r <= sin_s1_r;
    end
  end

  // transfer controller
  always_comb begin
    state_nxt   = state_r;
    half_nxt    = half_r;
    tx_sh_nxt   = tx_sh_r;
    rx_sh_nxt   = rx_sh_r;
    txbuf_nxt   = txbuf_r;
    txbuf_v_nxt = txbuf_v_r;
    sck_nxt     = sck_r;
    mosi_nxt    = mosi_r;
    lead        = ~half_r[0];
    sample      = lead ^ clock_phase_bit;
    frame_done  = 1'b0;
    tc_set      = 1'b0;
    if (!master_spi_mode) begin
      state_nxt   = usm_pkg::USM_IDLE;
      txbuf_v_nxt = 1'b0;
      sck_nxt     = clock_polarity_bit;
      mosi_nxt    = usm_pkg::LINE_IDLE;
    end else begin
      unique case (state_r)
        usm_pkg::USM_IDLE: begin
          sck_nxt  = clock_polarity_bit;
          mosi_nxt = usm_pkg::LINE_IDLE;
          if (txbuf_v_r && transmitter_enable_bit) begin
            state_nxt   = usm_pkg::USM_SHIFT;
            txbuf_v_nxt = 1'b0;
            half_nxt    = usm_pkg::HALF_FIRST;
            tx_sh_nxt   = txbuf_r;
            if (!clock_phase_bit) begin
              mosi_nxt  = out_bit(txbuf_r, bit_order_select);
              tx_sh_nxt = shift_out(txbuf_r, bit_order_select);
            end
          end
        end
        usm_pkg::USM_SHIFT: begin
          if (tick) begin
            sck_nxt  = ~sck_r;
            half_nxt = half_r + usm_pkg::HALF_STEP;
            if (sample) begin
              rx_sh_nxt = shift_in(rx_sh_r, sin_s2_r, bit_order_select);
            end else if (half_r != usm_pkg::HALF_LAST || clock_phase_bit) begin
              mosi_nxt  = out_bit(tx_sh_r, bit_order_select);
              tx_sh_nxt = shift_out(tx_sh_r, bit_order_select);
            end
            if (half_r == usm_pkg::HALF_LAST) begin
              frame_done = 1'b1;
              // a queued byte rides straight on, making a gapless 16-bit word
              if (txbuf_v_r) begin
                txbuf_v_nxt = 1'b0;
                half_nxt    = usm_pkg::HALF_FIRST;
                tx_sh_nxt   = txbuf_r;
                if (!clock_phase_bit) begin
                  mosi_nxt  = out_bit(txbuf_r, bit_order_select);
                  tx_sh_nxt = shift_out(txbuf_r, bit_order_select);
                end
              end else begin
                state_nxt = usm_pkg::USM_IDLE;
                // phase 1 ends on a sample edge: the last bit must outlive it
                if (!clock_phase_bit) begin
                  mosi_nxt = usm_pkg::LINE_IDLE;
                end
                tc_set    = 1'b1;
              end
            end
          end
        end
      endcase
    end
    // a write into a full buffer is dropped, as the flag told software to wait
    if (master_spi_mode && transmitter_enable_bit && data_wr && !txbuf_v_r) begin
      txbuf_nxt   = data_wdata;
      txbuf_v_nxt = 1'b1;
    end
    tc_nxt     = tc_set | (tc_r & ~(tx_complete_clear | tx_complete_ack));
    bempty_nxt = ~txbuf_v_nxt;
    // disabling waits for queued data before the pin is handed back
    tx_oe_nxt  = master_spi_mode & (transmitter_enable_bit | txbuf_v_nxt |
                          (state_nxt == usm_pkg::USM_SHIFT));
  end

  assign rx_byte = rx_sh_nxt;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r   <= usm_pkg::USM_IDLE;
      half_r    <= usm_pkg::HALF_FIRST;
      tx_sh_r   <= usm_pkg::BYTE_ZERO;
      rx_sh_r   <= usm_pkg::BYTE_ZERO;
      txbuf_r   <= usm_pkg::BYTE_ZERO;
      txbuf_v_r <= 1'b0;
      sck_r     <= 1'b0;
      mosi_r    <= usm_pkg::LINE_IDLE;
      tc_r      <= 1'b0;
      bempty_r  <= usm_pkg::BUF_EMPTY_RST;
      tx_oe_r   <= 1'b0;
      rx_own_r  <= 1'b0;
      clk_oe_r  <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      half_r    <= half_nxt;
      tx_sh_r   <= tx_sh_nxt;
      rx_sh_r   <= rx_sh_nxt;
      txbuf_r   <= txbuf_nxt;
      txbuf_v_r <= txbuf_v_nxt;
      sck_r     <= sck_nxt;
      mosi_r    <= mosi_nxt;
      tc_r      <= tc_nxt;
      bempty_r  <= bempty_nxt;
      tx_oe_r   <= tx_oe_nxt;
      rx_own_r  <= master_spi_mode & receiver_enable_bit;
      clk_oe_r  <= clock_pin_direction;
    end
  end

  // receive buffer: two slots plus a hold byte that the next arrival overwrites
  always_comb begin
    mem_nxt    = mem_r;
    rptr_nxt   = rptr_r;
    cnt_nxt    = cnt_r;
    hold_nxt   = hold_r;
    hold_v_nxt = hold_v_r;
    if (!master_spi_mode || !receiver_enable_bit) begin
      cnt_nxt    = usm_pkg::CNT_ZERO;
      hold_v_nxt = 1'b0;
    end else begin
      if (data_rd && cnt_r != usm_pkg::CNT_ZERO) begin
        rptr_nxt = ~rptr_r;
        if (hold_v_r) begin
          mem_nxt[rptr_r] = hold_r;
          hold_v_nxt      = 1'b0;
        end else begin
          cnt_nxt = cnt_r - usm_pkg::CNT_STEP;
        end
      end
      if (frame_done) begin
        if (cnt_nxt != usm_pkg::CNT_FULL) begin
          mem_nxt[rptr_nxt ^ cnt_nxt[0]] = rx_byte;
          cnt_nxt = cnt_nxt + usm_pkg::CNT_STEP;
        end else begin
          hold_nxt   = rx_byte;
          hold_v_nxt = 1'b1;
        end
      end
    end
    rdata_nxt = mem_nxt[rptr_nxt];
    rxc_nxt   = (cnt_nxt != usm_pkg::CNT_ZERO);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mem_r    <= '{default: usm_pkg::BYTE_ZERO};
      rptr_r   <= 1'b0;
      cnt_r    <= usm_pkg::CNT_ZERO;
      hold_r   <= usm_pkg::BYTE_ZERO;
      hold_v_r <= 1'b0;
      rdata_r  <= usm_pkg::BYTE_ZERO;
      rxc_r    <= 1'b0;
    end else begin
      mem_r    <= mem_nxt;
      rptr_r   <= rptr_nxt;
      cnt_r    <= cnt_nxt;
      hold_r   <= hold_nxt;
      hold_v_r <= hold_v_nxt;
      rdata_r  <= rdata_nxt;
      rxc_r    <= rxc_nxt;
    end
  end

  assign data_rdata             = rdata_r;
  assign transmit_complete_flag = tc_r;
  assign receive_complete_flag  = rxc_r;
  assign buffer_empty_flag      = bempty_r;
  assign framing_error_flag     = 1'b0;
  assign overrun_flag           = 1'b0;
  assign parity_error_flag      = 1'b0;
  assign transfer_clock_pin     = sck_r;
  assign transfer_clock_oe      = clk_oe_r;
  assign serial_output_pin      = mosi_r;
  assign serial_output_oe       = tx_oe_r;
  assign serial_input_owned     = rx_own_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_idle_clock;
    (state_r == usm_pkg::USM_IDLE && $past(state_r) == usm_pkg::USM_IDLE &&
     $stable(clock_polarity_bit) && !$past(rst)) |-> transfer_clock_pin == clock_polarity_bit;
  endproperty
  a_idle_clock: assert property (p_idle_clock) else $error("clock not at idle level");

  property p_idle_line;
    (state_r == usm_pkg::USM_IDLE && $past(state_r) == usm_pkg::USM_IDLE)
      |-> serial_output_pin == usm_pkg::LINE_IDLE;
  endproperty
  a_idle_line: assert property (p_idle_line) else $error("data line not idle high");

  property p_mode_off;
    !master_spi_mode |=> state_r == usm_pkg::USM_IDLE && !txbuf_v_r;
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("transfer outside spi mode");

  property p_errors_zero;
    !framing_error_flag && !overrun_flag && !parity_error_flag;
  endproperty
  a_errors_zero: assert property (p_errors_zero) else $error("error flag set");

  property p_load_free;
    (master_spi_mode && state_r == usm_pkg::USM_IDLE && txbuf_v_r && transmitter_enable_bit)
      |=> state_r == usm_pkg::USM_SHIFT && !txbuf_v_r && half_r == usm_pkg::HALF_FIRST;
  endproperty
  a_load_free: assert property (p_load_free) else $error("buffer not loaded");

  property p_write_busy;
    (master_spi_mode && transmitter_enable_bit && data_wr && !txbuf_v_r) |=> !buffer_empty_flag;
  endproperty
  a_write_busy: assert property (p_write_busy) else $error("buffer empty after write");

  property p_done_flag;
    (master_spi_mode && state_r == usm_pkg::USM_SHIFT && tick && half_r == usm_pkg::HALF_LAST &&
     !txbuf_v_r) |=> transmit_complete_flag && state_r == usm_pkg::USM_IDLE;
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("tx complete not set");

  property p_chain;
    (master_spi_mode && state_r == usm_pkg::USM_SHIFT && tick && half_r == usm_pkg::HALF_LAST &&
     txbuf_v_r) |=> (state_r == usm_pkg::USM_SHIFT && !transmit_complete_flag)[*2];
  endproperty
  a_chain: assert property (p_chain) else $error("gap or early complete in 16-bit");

  property p_tc_clear;
    ((tx_complete_clear || tx_complete_ack) && !tc_set) |=> !transmit_complete_flag;
  endproperty
  a_tc_clear: assert property (p_tc_clear) else $error("tx complete not cleared");

  property p_rx_flush;
    !receiver_enable_bit |=> !receive_complete_flag;
  endproperty
  a_rx_flush: assert property (p_rx_flush) else $error("rx buffer not flushed");

endmodule

/* File: hdl/usm_pkg.sv */
// constants and types shared by the usart spi master block
// assumes a single ref_clk domain with synchronous reset
package usm_pkg;

  localparam int          DIV_W      = 12;
  localparam int          FRAME_BITS = 8;
  localparam int          RX_DEPTH   = 2;
  localparam logic [1:0]  MODE_MASTER_SPI_MODE = 2'h3;
  localparam logic        LINE_IDLE  = 1'h1;
  localparam logic [3:0]  HALF_FIRST = 4'h0;
  localparam logic [3:0]  HALF_LAST  = 4'hf;
  localparam logic [3:0]  HALF_STEP  = 4'h1;
  localparam logic [1:0]  CNT_ZERO   = 2'h0;
  localparam logic [1:0]  CNT_FULL   = 2'h2;
  localparam logic [1:0]  CNT_STEP   = 2'h1;
  localparam logic [7:0]  BYTE_ZERO  = 8'h00;
  localparam logic        BUF_EMPTY_RST = 1'h1;

  typedef enum logic {
    USM_IDLE,
    USM_SHIFT
  } usm_state_e;

endpackage
